// >>> sbrg_top.v
`timescale 1ns/1ps
`include "sbrg_map.vh"

module sbrg_top
(
   input  wire        ref_clk,
   input  wire        rst,
   input  wire        wb_cyc_i,
   input  wire        wb_stb_i,
   input  wire        wb_we_i,
   input  wire [5:2]  wb_adr_i,
   input  wire [3:0]  wb_sel_i,
   input  wire [31:0] wb_dat_i,
   output reg  [31:0] wb_dat_o,
   output reg         wb_ack_o,
   input  wire        rx_byte_valid,
   input  wire [7:0]  rx_byte_data,
   input  wire        rx_byte_ninth,
   input  wire        rx_byte_stop_bad,
   input  wire        tx_idle,
   output reg         baud_tick_q,
   output reg         irq_q
);

   reg  [7:0]  baud_divisor_q;
   reg  [7:0]  txctrl_q;
   reg  [7:0]  rxctrl_q;
   reg  [7:0]  rxdata_q;
   reg         rx_full_q;
   reg  [2:0]  irq_stat_q;
   reg  [2:0]  irq_mask_q;
   reg  [5:0]  pre_last;
   wire        req;
   wire        wr;
   wire        rd;
   wire        wr_lane0;
   wire        div_write;
   wire        pre_strobe;
   wire [7:0]  timer_count;
   wire        timer_tick;
   wire        sync_mode;
   wire        high_speed_select;
   wire        rx_read;
   wire        overrun;
   wire [2:0]  irq_events;

   assign req       = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wr        = req & wb_we_i;
   assign rd        = req & ~wb_we_i;
   assign wr_lane0  = wr & wb_sel_i[0];
   assign div_write = wr_lane0 && (wb_adr_i == `SBRG_OFF_DIVISOR);
   assign rx_read   = rd && (wb_adr_i == `SBRG_OFF_RXDATA);

   assign sync_mode         = txctrl_q[`SBRG_TX_SYNC_BIT];
   assign high_speed_select = txctrl_q[`SBRG_TX_HS_BIT];

   always @*
   begin
      if (sync_mode)
         pre_last = `SBRG_PRE_SYNC;
      else if (high_speed_select)
         pre_last = `SBRG_PRE_ASYNC_HI;
      else
         pre_last = `SBRG_PRE_ASYNC_LO;
   end

   sbrg_prescaler u_pre
   (
      .ref_clk  (ref_clk),
      .rst      (rst),
      .restart  (div_write),
      .last     (pre_last),
      .strobe_q (pre_strobe)
   );

   sbrg_timer u_timer
   (
      .ref_clk (ref_clk),
      .rst     (rst),
      .restart (div_write),
      .step    (pre_strobe),
      .divisor (baud_divisor_q),
      .count_q (timer_count),
      .tick_q  (timer_tick)
   );

   always @(posedge ref_clk)
   begin
      if (rst)
         baud_tick_q <= 1'b0;
      else
         baud_tick_q <= timer_tick;
   end

   // overrun: new byte while buffer still unread
   assign overrun = rx_byte_valid & rx_full_q & ~rx_read;

   always @(posedge ref_clk)
   begin
      if (rst)
      begin
         baud_divisor_q <= `SBRG_DIVISOR_RST;
         txctrl_q       <= `SBRG_TXCTRL_RST;
         irq_mask_q     <= 3'h0;
      end
      else if (wr_lane0)
      begin
         case (wb_adr_i)
            `SBRG_OFF_DIVISOR:
               baud_divisor_q <= wb_dat_i[7:0];
            `SBRG_OFF_TXCTRL:
               txctrl_q <= wb_dat_i[7:0] & 8'hF4;
            `SBRG_OFF_IRQ_MASK:
               irq_mask_q <= wb_dat_i[2:0];
            default:
               irq_mask_q <= irq_mask_q;
         endcase
      end
   end

   // receive control: software bits and hardware flags
   always @(posedge ref_clk)
   begin
      if (rst)
      begin
         rxctrl_q  <= `SBRG_RXCTRL_RST;
         rxdata_q  <= 8'h00;
         rx_full_q <= 1'b0;
      end
      else
      begin
         if (wr_lane0 && wb_adr_i == `SBRG_OFF_RXCTRL)
         begin
            rxctrl_q[7:3] <= wb_dat_i[7:3];
            if (!wb_dat_i[`SBRG_RX_CONTINUOUS_RECEIVE_ENABLE_BIT])
               rxctrl_q[`SBRG_RX_OVERRUN_ERROR_FLAG_BIT] <= 1'b0;
         end
         if (rx_read)
            rx_full_q <= 1'b0;
         // receiver stalls while overrun stands
         if (rx_byte_valid && rxctrl_q[`SBRG_RX_CONTINUOUS_RECEIVE_ENABLE_BIT]
             && !rxctrl_q[`SBRG_RX_OVERRUN_ERROR_FLAG_BIT])
         begin
            if (overrun)
               rxctrl_q[`SBRG_RX_OVERRUN_ERROR_FLAG_BIT] <= 1'b1;
            else
            begin
               rxdata_q  <= rx_byte_data;
               rx_full_q <= 1'b1;
               rxctrl_q[`SBRG_RX_NINTH_BIT] <= rx_byte_ninth;
               rxctrl_q[`SBRG_RX_FRAMING_ERROR_FLAG_BIT]  <= rx_byte_stop_bad;
            end
         end
      end
   end

   assign irq_events = {overrun & rxctrl_q[`SBRG_RX_CONTINUOUS_RECEIVE_ENABLE_BIT],
                        rx_byte_valid & rx_byte_stop_bad & rxctrl_q[`SBRG_RX_CONTINUOUS_RECEIVE_ENABLE_BIT],
                        timer_tick};

   // set wins over write-one-to-clear
   always @(posedge ref_clk)
   begin
      if (rst)
         irq_stat_q <= 3'h0;
      else if (wr_lane0 && wb_adr_i == `SBRG_OFF_IRQ_STAT)
         irq_stat_q <= (irq_stat_q & ~wb_dat_i[2:0]) | irq_events;
      else
         irq_stat_q <= irq_stat_q | irq_events;
   end

   always @(posedge ref_clk)
   begin
      if (rst)
         irq_q <= 1'b0;
      else
         irq_q <= |(irq_stat_q & irq_mask_q);
   end

   // one-cycle ack; unmapped reads return zero
   always @(posedge ref_clk)
   begin
      if (rst)
      begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end
      else
      begin
         wb_ack_o <= req;
         wb_dat_o <= 32'h0000_0000;
         if (rd)
         begin
            case (wb_adr_i)
               `SBRG_OFF_DIVISOR:
                  wb_dat_o <= {24'h000000, baud_divisor_q};
               `SBRG_OFF_TXCTRL:
                  wb_dat_o <= {24'h000000, txctrl_q[7:2], tx_idle, 1'b0};
               `SBRG_OFF_RXCTRL:
                  wb_dat_o <= {24'h000000, rxctrl_q};
               `SBRG_OFF_RXDATA:
                  wb_dat_o <= {24'h000000, rxdata_q};
               `SBRG_OFF_IRQ_STAT:
                  wb_dat_o <= {29'h00000000, irq_stat_q};
               `SBRG_OFF_IRQ_MASK:
                  wb_dat_o <= {29'h00000000, irq_mask_q};
               default:
                  wb_dat_o <= 32'h0000_0000;
            endcase
         end
      end
   end

endmodule

// >>> sbrg_map.vh
`ifndef SBRG_MAP_VH
`define SBRG_MAP_VH

// register word offsets (compared with wb_adr_i[5:2])
`define SBRG_OFF_DIVISOR   4'h0
`define SBRG_OFF_TXCTRL    4'h1
`define SBRG_OFF_RXCTRL    4'h2
`define SBRG_OFF_RXDATA    4'h3
`define SBRG_OFF_IRQ_STAT  4'h4
`define SBRG_OFF_IRQ_MASK  4'h5

// transmit_status_control fields
`define SBRG_TX_SYNC_BIT   4
`define SBRG_TX_HS_BIT     2
`define SBRG_TX_IDLE_BIT   1
`define SBRG_TXCTRL_RST    8'h02

// receive_status_control fields
`define SBRG_RX_PORTEN_BIT 7
`define SBRG_RX_CONTINUOUS_RECEIVE_ENABLE_BIT   4
`define SBRG_RX_ADDRESS_DETECT_ENABLE_BIT  3
`define SBRG_RX_FRAMING_ERROR_FLAG_BIT   2
`define SBRG_RX_OVERRUN_ERROR_FLAG_BIT   1
`define SBRG_RX_NINTH_BIT  0
`define SBRG_RXCTRL_RST    8'h00

`define SBRG_DIVISOR_RST   8'h00

// prescale divide factors minus one
`define SBRG_PRE_ASYNC_LO  6'h3F
`define SBRG_PRE_ASYNC_HI  6'h0F
`define SBRG_PRE_SYNC      6'h03

// interrupt status bits
`define SBRG_IRQ_TICK_BIT  0
`define SBRG_IRQ_FRAMING_ERROR_FLAG_BIT  1
`define SBRG_IRQ_OVERRUN_ERROR_FLAG_BIT  2
`define SBRG_IRQ_W         3

`endif

// >>> sbrg_prescaler.v
`timescale 1ns/1ps
`include "sbrg_map.vh"

module sbrg_prescaler
(
   input  wire       ref_clk,
   input  wire       rst,
   input  wire       restart,
   input  wire [5:0] last,
   output reg        strobe_q
);

   reg  [5:0] cnt_q;

   always @(posedge ref_clk)
   begin
      if (rst || restart)
      begin
         cnt_q    <= 6'h00;
         strobe_q <= 1'b0;
      end
      else if (cnt_q >= last)
      begin
         cnt_q    <= 6'h00;
         strobe_q <= 1'b1;
      end
      else
      begin
         cnt_q    <= cnt_q + 6'h01;
         strobe_q <= 1'b0;
      end
   end

endmodule

// >>> sbrg_timer.v
`timescale 1ns/1ps
`include "sbrg_map.vh"

module sbrg_timer
(
   input  wire       ref_clk,
   input  wire       rst,
   input  wire       restart,
   input  wire       step,
   input  wire [7:0] divisor,
   output reg  [7:0] count_q,
   output reg        tick_q
);

   always @(posedge ref_clk)
   begin
      if (rst || restart)
      begin
         count_q <= 8'h00;
         tick_q  <= 1'b0;
      end
      else if (step && count_q >= divisor)
      begin
         count_q <= 8'h00;
         tick_q  <= 1'b1;
      end
      else
      begin
         if (step)
            count_q <= count_q + 8'h01;
         tick_q  <= 1'b0;
      end
   end

endmodule

// >>> sbrg_chk.sv
`timescale 1ns/1ps
module sbrg_chk
(
   input wire        ref_clk,
   input wire        rst,
   input wire        wb_we_i,
   input wire [5:2]  wb_adr_i,
   input wire [3:0]  wb_sel_i,
   input wire [31:0] wb_dat_i,
   input wire        wb_ack_o,
   input wire        baud_tick_q
);
   reg  [14:0] cnt_q;
   reg  [7:0]  n_q;
   reg         sync_q;
   reg         hs_q;
   reg         ok_q;
   wire        wr = wb_ack_o & wb_we_i & wb_sel_i[0];
   wire        cfg = wr & (wb_adr_i == 4'h0 | wb_adr_i == 4'h1);
   wire [14:0] per_w = (sync_q ? 15'h4 : hs_q ? 15'h10 : 15'h40) * (n_q + 15'h1);
   // period only trusted after a tick with no settings change since
   always @(posedge ref_clk)
   begin
      if (rst)
      begin
         cnt_q <= 15'h0;
         n_q <= 8'h00;
         sync_q <= 1'b0;
         hs_q <= 1'b0;
         ok_q <= 1'b0;
      end
      else
      begin
         cnt_q <= (baud_tick_q | cfg) ? 15'h1 : cnt_q + 15'h1;
         ok_q <= cfg ? 1'b0 : (baud_tick_q | ok_q);
         if (wr & wb_adr_i == 4'h0)
            n_q <= wb_dat_i[7:0];
         if (wr & wb_adr_i == 4'h1)
            {sync_q, hs_q} <= {wb_dat_i[4], wb_dat_i[2]};
      end
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held too long");
   a_tick_pulse: assert property (baud_tick_q |=> !baud_tick_q)
      else $error("tick held too long");
   a_free_run: assert property (cnt_q < 15'h4006)
      else $error("tick missing");
   a_async_period: assert property (baud_tick_q && ok_q && !sync_q |-> cnt_q == per_w)
      else $error("async period wrong");
   a_sync_period: assert property (baud_tick_q && ok_q && sync_q |-> cnt_q == per_w)
      else $error("sync period wrong");
   a_write_restart: assert property (wr && wb_adr_i == 4'h0 |-> ##1 !baud_tick_q [*3])
      else $error("stale tick after divisor write");
endmodule
bind sbrg_top sbrg_chk u_chk (.ref_clk(ref_clk), .rst(rst), .wb_we_i(wb_we_i),
   .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
   .wb_ack_o(wb_ack_o), .baud_tick_q(baud_tick_q));

// >>> tb_sbrg_top.sv
`timescale 1ns/1ps
module tb_sbrg_top;
   reg         ref_clk, rst, wb_cyc_i, wb_stb_i, wb_we_i, rx_byte_valid, rx_byte_stop_bad;
   reg         rx_byte_ninth, tx_idle;
   reg  [3:0]  wb_adr_i, wb_sel_i;
   reg  [31:0] wb_dat_i, r;
   reg  [7:0]  rx_byte_data, n, d;
   wire [31:0] wb_dat_o;
   wire        wb_ack_o, baud_tick_q, irq_q;
   integer     errors, cmp_count, seed, cyc_n, t, i;
   always #5 ref_clk = ~ref_clk;
   sbrg_top DUT (.ref_clk(ref_clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rx_byte_valid(rx_byte_valid),
      .rx_byte_data(rx_byte_data), .rx_byte_ninth(rx_byte_ninth),
      .rx_byte_stop_bad(rx_byte_stop_bad),
      .tx_idle(tx_idle), .baud_tick_q(baud_tick_q), .irq_q(irq_q));
   function integer exp_per(input s, input h, input [7:0] v);
      begin
         exp_per = (s ? 4 : h ? 16 : 64) * (v + 1);
      end
   endfunction
   task conclude;
      begin
         $display("comparisons %0d mismatches %0d", cmp_count, errors);
         if (errors == 0 && cmp_count > 0)
            $display("Simulation passed");
         else
            $display("Simulation failed");
         $finish;
      end
   endtask
   task chk(input [31:0] s, input [31:0] e);
      begin
         cmp_count = cmp_count + 1;
         if (s !== e)
         begin
            errors = errors + 1;
            $display("ERROR %0t saw %h expected %h", $time, s, e);
         end
      end
   endtask
   // request held until ack is sampled high at a rising edge
   task wb(input w, input [3:0] a, input [7:0] v);
      begin
         wb_cyc_i <= 1'b1;
         wb_stb_i <= 1'b1;
         wb_we_i <= w;
         wb_adr_i <= a;
         wb_dat_i <= {24'h0, v};
         @(posedge ref_clk);
         while (wb_ack_o !== 1'b1)
            @(posedge ref_clk);
         r = wb_dat_o;
         wb_cyc_i <= 1'b0;
         wb_stb_i <= 1'b0;
         @(posedge ref_clk);
      end
   endtask
   task rc(input [3:0] a, input [31:0] e);
      begin
         wb(1'b0, a, 8'h00);
         chk(r, e);
      end
   endtask
   task rx(input [7:0] v, input b);
      begin
         rx_byte_valid <= 1'b1;
         rx_byte_data <= v;
         rx_byte_stop_bad <= b;
         @(posedge ref_clk);
         rx_byte_valid <= 1'b0;
         @(posedge ref_clk);
      end
   endtask
   task per;
      begin
         @(negedge ref_clk);
         while (baud_tick_q !== 1'b1)
            @(negedge ref_clk);
         @(negedge ref_clk);
         t = 1;
         while (baud_tick_q !== 1'b1)
         begin
            @(negedge ref_clk);
            t = t + 1;
         end
         @(posedge ref_clk);
      end
   endtask
   always @(posedge ref_clk)
   begin
      cyc_n = cyc_n + 1;
      if (cyc_n > 20000)
      begin
         errors = errors + 1;
         conclude;
      end
   end
   initial
   begin
      {ref_clk, wb_cyc_i, wb_stb_i, wb_we_i, rx_byte_valid, rx_byte_stop_bad} = 6'h00;
      {wb_adr_i, wb_dat_i, rx_byte_data} = 44'h0;
      {rx_byte_ninth, tx_idle, wb_sel_i} = 6'h11;
      {errors, cmp_count, cyc_n, seed} = {32'h0, 32'h0, 32'h0, 32'h59};
      rst = 1'b1;
      repeat (20) @(posedge ref_clk);
      rst <= 1'b0;
      @(posedge ref_clk);
      rc(4'h0, 32'h0);
      rc(4'h1, 32'h2);
      rc(4'h2, 32'h0);
      rc(4'h4, 32'h0);
      rc(4'h5, 32'h0);
      rc(4'h7, 32'h0);
      tx_idle <= 1'b0;
      rc(4'h1, 32'h0);
      tx_idle <= 1'b1;
      wb(1'b1, 4'h0, 8'h03);
      wb_sel_i <= 4'h0;
      wb(1'b1, 4'h0, 8'h55);
      wb_sel_i <= 4'h1;
      rc(4'h0, 32'h3);
      $display("reset test done");
      for (i = 0; i < 4; i = i + 1)
      begin
         n = (i == 0) ? 8'h00 : (i == 3) ? 8'hFF : $random(seed) & 8'h07;
         wb(1'b1, 4'h1, {3'h0, i[1], 1'b0, i[0], 2'h0});
         wb(1'b1, 4'h0, n);
         per;
         chk(t, exp_per(i[1], i[0], n));
      end
      $display("rate test done");
      wb(1'b1, 4'h1, 8'h00);
      wb(1'b1, 4'h0, 8'hC8);
      repeat (50) @(posedge ref_clk);
      wb(1'b1, 4'h0, 8'h01);
      t = 0;
      @(negedge ref_clk);
      while (baud_tick_q !== 1'b1)
      begin
         @(negedge ref_clk);
         t = t + 1;
      end
      @(posedge ref_clk);
      chk(t > 120 && t < 135, 1);
      $display("restart test done");
      wb(1'b1, 4'h2, 8'h90);
      d = $random(seed);
      rx(d, 1'b1);
      rc(4'h2, 32'h94);
      rc(4'h3, d);
      rx(d, 1'b0);
      rc(4'h2, 32'h90);
      rc(4'h3, d);
      rx(8'h5A, 1'b0);
      rx(8'hA5, 1'b0);
      rc(4'h2, 32'h92);
      rc(4'h3, 32'h5A);
      rx(8'h33, 1'b1);
      rc(4'h2, 32'h92);
      wb(1'b1, 4'h2, 8'h80);
      rc(4'h2, 32'h80);
      wb(1'b1, 4'h2, 8'h90);
      rx_byte_ninth <= 1'b1;
      rx(8'h66, 1'b0);
      rx_byte_ninth <= 1'b0;
      rc(4'h2, 32'h91);
      rc(4'h3, 32'h66);
      $display("receive test done");
      chk(irq_q, 0);
      wb(1'b1, 4'h5, 8'h06);
      chk(irq_q, 1);
      wb(1'b1, 4'h4, 8'h06);
      chk(irq_q, 0);
      $display("irq test done");
      conclude;
   end
endmodule
